// ==== lms_pkg.sv ====
// shared constants and types for the led matrix scan and gain block
package lms_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_INIT   = 12'h000;
	localparam logic [11:0] OFS_CFG1   = 12'h004;
	localparam logic [11:0] OFS_CFG2   = 12'h008;
	localparam logic [11:0] OFS_CFG3   = 12'h00c;
	localparam logic [11:0] OFS_CHIP   = 12'h010;
	localparam logic [11:0] OFS_PEAK   = 12'h014;
	localparam logic [11:0] OFS_COLOR  = 12'h018;
	localparam logic [11:0] OFS_FSYNC  = 12'h024;
	localparam logic [11:0] OFS_STATUS = 12'h028;
	localparam logic [11:0] OFS_DOT    = 12'h400;
	// reset values, dropped peak code, fewest scan lines
	localparam logic [1:0] RST_SCAN  = 2'h2;
	localparam logic [1:0] RST_MODE  = 2'h1;
	localparam logic [2:0] RST_PEAK  = 3'h3;
	localparam logic [6:0] RST_COLOR = 7'h40;
	localparam logic [7:0] RST_DOT   = 8'h80;
	localparam logic [2:0] PEAK_BAD  = 3'h7;
	localparam int        SCAN_MIN  = 6;
	// timing, in picoseconds, and derived cycle counts
	localparam int CLK_PS      = 40000;
	localparam int T_PWM_F_PS  = 8000000;
	localparam int T_PWM_S_PS  = 16000000;
	localparam int T_BLK_L_PS  = 1000000;
	localparam int T_BLK_S_PS  = 500000;
	localparam int T_PHASE_PS  = 125000;
	localparam int T_DLY_F_PS  = 62500;
	localparam int T_DLY_S_PS  = 31250;
	localparam int CNT_W       = 10;
	localparam logic [CNT_W-1:0] CYC_PWM_F =
		CNT_W'((T_PWM_F_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_PWM_S =
		CNT_W'((T_PWM_S_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_BLK_L =
		CNT_W'((T_BLK_L_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_BLK_S =
		CNT_W'((T_BLK_S_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_PHASE =
		CNT_W'((T_PHASE_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_DLY_F =
		CNT_W'((T_DLY_F_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_DLY_S =
		CNT_W'((T_DLY_S_PS + CLK_PS - 1) / CLK_PS);

	typedef enum logic [1:0] {
		SC_IDLE  = 2'b00,
		SC_LINE  = 2'b01,
		SC_BLANK = 2'b11
	} lms_scan_e;

	// drive set for one current sink
	typedef struct packed {
		logic [16:0] currentUa;
		logic [7:0]  dotGain;
		logic [6:0]  colorGain;
		logic [1:0]  lowLevelComp;
	} lms_sink_s;

	// peak current in half milliamps for each code
	function automatic logic [7:0] peak_half_ma(input logic [2:0] code);
		case (code)
			3'h0: peak_half_ma = 8'd15;
			3'h1: peak_half_ma = 8'd25;
			3'h2: peak_half_ma = 8'd50;
			3'h3: peak_half_ma = 8'd75;
			3'h4: peak_half_ma = 8'd100;
			3'h5: peak_half_ma = 8'd150;
			default: peak_half_ma = 8'd200;
		endcase
	endfunction

	// sink current = peak * color/127 * dot/255, in microamps
	function automatic logic [16:0] sink_ua(input logic [2:0] code,
		input logic [6:0] cc, input logic [7:0] dc);
		logic [31:0] p;
		p = 32'(peak_half_ma(code)) * 32'd500 * 32'(cc) * 32'(dc);
		sink_ua = 17'(p / 32'd32385);
	endfunction
endpackage

// ==== lms_scan_gain.sv ====
// led matrix scan sequencer and analog current gain registers
`timescale 1ns/1ps
`default_nettype none
module lms_scan_gain
	import lms_pkg::*;
#(
	parameter int NUM_LINES = 8,
	parameter int NUM_SINKS = 18
) (
	input  wire logic                        clk,           // 25 MHz clock
	input  wire logic                        srst,          // sync reset
	input  wire logic                        psel,          // apb select
	input  wire logic                        penable,       // apb enable
	input  wire logic                        pwrite,        // apb direction
	input  wire logic [11:0]                 paddr,         // apb address
	input  wire logic [31:0]                 pwdata,        // apb write data
	output logic      [31:0]                 prdata,        // apb read data
	output logic                             pready,        // apb ready
	output logic                             pslverr,       // apb error
	output logic      [NUM_LINES-1:0]        lineOn,        // scan switch on
	output logic      [NUM_SINKS-1:0]        sinkOn,        // sink active
	output logic      [1:0]                  lineDischarge, // upside de-ghost
	output logic      [1:0]                  sinkPrecharge, // downside de-ghost
	output logic      [2:0]                  peakCurrentCode, // live code
	output lms_sink_s [NUM_SINKS-1:0]        sinkCtl        // per-sink gains
);
	localparam int NUM_DOTS = NUM_LINES * NUM_SINKS;

	// refuse sizes the scan and address map cannot serve
	if (NUM_LINES != 8 || NUM_SINKS % 3 != 0 || NUM_DOTS > 256) begin : g_chk
		$error("lms_scan_gain: unsupported matrix size");
	end

	// configuration registers
	logic [1:0]  scanCode_r;
	logic        slowPwm_r;
	logic [1:0]  refreshMode_r;
	logic        shortBlank_r;
	logic        phaseEn_r;
	logic        csDelayEn_r;
	logic [1:0]  comp_r [3];
	logic        chipEn_r;
	logic        chipEnPrev_r;
	logic [2:0]  peakPend_r;
	logic [2:0]  peakAct_r;
	logic [1:0]  upPend_r;
	logic [1:0]  upAct_r;
	logic [1:0]  downPend_r;
	logic [1:0]  downAct_r;
	logic [6:0]  colorPend_r [3];
	logic [6:0]  colorAct_r [3];
	logic [7:0]  dotPend_r [NUM_DOTS];
	logic [7:0]  dotAct_r [NUM_DOTS];

	// scan state
	lms_scan_e   state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [2:0]  line_r;

	// bus decode
	logic        access;
	logic        wr;
	logic        dotHit;
	logic [9:0]  dotOfs;
	logic [7:0]  dotIdx;
	logic        regHit;
	logic        immediate;
	logic        latchOk;
	logic        fsync;

	assign access  = psel & penable;
	assign wr      = access & pwrite;
	assign dotOfs  = 10'(paddr - OFS_DOT);
	assign dotIdx  = dotOfs[9:2];
	assign dotHit  = paddr >= OFS_DOT && paddr[1:0] == 2'b00
		&& paddr < OFS_DOT + 12'(4 * NUM_DOTS);
	assign immediate = refreshMode_r <= 2'h1;
	// peak and de-ghost writes only land while chip is disabled outside modes zero and one
	assign latchOk = immediate | ~chipEn_r;
	assign fsync   = wr && paddr == OFS_FSYNC && pwdata[0];
	assign pready  = 1'b1;
	assign pslverr = access & ~(regHit | dotHit);

	// register read mux; zero-wait answer in the access cycle
	always_comb begin
		regHit = 1'b1;
		prdata = 32'h0;
		case (paddr)
			OFS_INIT:  prdata = {26'h0, refreshMode_r, 1'b0, slowPwm_r,
				scanCode_r};
			OFS_CFG1:  prdata = {29'h0, csDelayEn_r, phaseEn_r,
				shortBlank_r};
			OFS_CFG2:  prdata = {26'h0, comp_r[2], comp_r[1], comp_r[0]};
			OFS_CFG3:  prdata = {28'h0, downPend_r, upPend_r};
			OFS_CHIP:  prdata = {31'h0, chipEn_r};
			OFS_PEAK:  prdata = {29'h0, peakPend_r};
			OFS_COLOR: prdata = {25'h0, colorPend_r[0]};
			OFS_COLOR + 12'h004: prdata = {25'h0, colorPend_r[1]};
			OFS_COLOR + 12'h008: prdata = {25'h0, colorPend_r[2]};
			OFS_FSYNC: prdata = 32'h0;
			OFS_STATUS: prdata = {15'h0, chipEn_r, downAct_r, upAct_r,
				1'b0, peakAct_r, 2'b00, state_r, 1'b0, line_r};
			default: begin
				regHit = 1'b0;
				if (dotHit) begin
					prdata = {24'h0, dotPend_r[dotIdx]};
				end
			end
		endcase
	end

	// plain configuration fields, effective at once
	always_ff @(posedge clk) begin
		if (srst) begin
			scanCode_r    <= RST_SCAN;
			slowPwm_r     <= 1'b0;
			refreshMode_r <= RST_MODE;
			shortBlank_r  <= 1'b0;
			phaseEn_r     <= 1'b0;
			csDelayEn_r   <= 1'b0;
			chipEn_r      <= 1'b0;
			chipEnPrev_r  <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				comp_r[i] <= 2'h0;
			end
		end else begin
			chipEnPrev_r <= chipEn_r;
			if (wr && paddr == OFS_INIT) begin
				scanCode_r    <= pwdata[1:0];
				slowPwm_r     <= pwdata[2];
				refreshMode_r <= pwdata[5:4];
			end
			if (wr && paddr == OFS_CFG1) begin
				shortBlank_r <= pwdata[0];
				phaseEn_r    <= pwdata[1];
				csDelayEn_r  <= pwdata[2];
			end
			if (wr && paddr == OFS_CFG2) begin
				comp_r[0] <= pwdata[1:0];
				comp_r[1] <= pwdata[3:2];
				comp_r[2] <= pwdata[5:4];
			end
			if (wr && paddr == OFS_CHIP) begin
				chipEn_r <= pwdata[0];
			end
		end
	end

	// peak current and de-ghost: pending copy, live copy per refresh mode
	always_ff @(posedge clk) begin
		if (srst) begin
			peakPend_r <= RST_PEAK;
			peakAct_r  <= RST_PEAK;
			upPend_r   <= 2'h0;
			upAct_r    <= 2'h0;
			downPend_r <= 2'h0;
			downAct_r  <= 2'h0;
		end else begin
			// code 111 has no current step, so it is dropped
			if (wr && paddr == OFS_PEAK && latchOk
				&& pwdata[2:0] != PEAK_BAD) begin
				peakPend_r <= pwdata[2:0];
				if (immediate) begin
					peakAct_r <= pwdata[2:0];
				end
			end
			if (wr && paddr == OFS_CFG3 && latchOk) begin
				upPend_r   <= pwdata[1:0];
				downPend_r <= pwdata[3:2];
				if (immediate) begin
					upAct_r   <= pwdata[1:0];
					downAct_r <= pwdata[3:2];
				end
			end
			// pending values go live on the enable's rising edge
			if (!immediate && chipEn_r && !chipEnPrev_r) begin
				peakAct_r <= peakPend_r;
				upAct_r   <= upPend_r;
				downAct_r <= downPend_r;
			end
		end
	end

	// color and dot gains: shown at once in modes zero and one, else on frame sync
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < 3; i++) begin
				colorPend_r[i] <= RST_COLOR;
				colorAct_r[i]  <= RST_COLOR;
			end
			for (int i = 0; i < NUM_DOTS; i++) begin
				dotPend_r[i] <= RST_DOT;
				dotAct_r[i]  <= RST_DOT;
			end
		end else begin
			if (fsync && !immediate) begin
				colorAct_r <= colorPend_r;
				dotAct_r   <= dotPend_r;
			end
			for (int i = 0; i < 3; i++) begin
				if (wr && paddr == OFS_COLOR + 12'(4 * i)) begin
					colorPend_r[i] <= pwdata[6:0];
					if (immediate) begin
						colorAct_r[i] <= pwdata[6:0];
					end
				end
			end
			if (wr && dotHit) begin
				dotPend_r[dotIdx] <= pwdata[7:0];
				if (immediate) begin
					dotAct_r[dotIdx] <= pwdata[7:0];
				end
			end
		end
	end

	// timing in cycles chosen by the configuration
	logic [CNT_W-1:0] tPwm;
	logic [CNT_W-1:0] tBlank;
	logic [CNT_W-1:0] tPhase;
	logic [CNT_W-1:0] tDelay;
	logic [CNT_W-1:0] lineLen;
	logic [2:0]       lastLine;

	assign tPwm    = slowPwm_r ? CYC_PWM_S : CYC_PWM_F;
	assign tBlank  = shortBlank_r ? CYC_BLK_S : CYC_BLK_L;
	assign tPhase  = phaseEn_r ? CYC_PHASE : '0;
	// one internal clock, longer at the slower pwm rate
	assign tDelay  = !csDelayEn_r ? '0
		: slowPwm_r ? CYC_DLY_F : CYC_DLY_S;
	assign lineLen = tPwm + 10'(2 * tPhase);
	// code 3 is treated as eight lines
	assign lastLine = scanCode_r == 2'h3 ? 3'h7
		: 3'(SCAN_MIN - 1) + 3'(scanCode_r);

	// group start within the line; the phase slot offsets groups
	function automatic logic [CNT_W-1:0] grp_start(input int g);
		grp_start = tDelay + CNT_W'(g) * tPhase;
	endfunction

	// scan sequencer; dropping the enable parks it idle
	always_ff @(posedge clk) begin
		if (srst || !chipEn_r) begin
			state_r <= SC_IDLE;
			cnt_r   <= '0;
			line_r  <= 3'h0;
		end else begin
			case (state_r)
				SC_IDLE: begin
					state_r <= SC_LINE;
					cnt_r   <= '0;
					line_r  <= 3'h0;
				end
				SC_LINE: begin
					if (cnt_r == lineLen - 1'b1) begin
						state_r <= SC_BLANK;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				SC_BLANK: begin
					if (cnt_r == tBlank - 1'b1) begin
						state_r <= SC_LINE;
						cnt_r   <= '0;
						// wrap after the last active line
						line_r  <= line_r >= lastLine ? 3'h0
							: line_r + 1'b1;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= SC_IDLE;
					cnt_r   <= '0;
					line_r  <= 3'h0;
				end
			endcase
		end
	end

	// line and sink drive, registered one cycle behind the counter
	always_ff @(posedge clk) begin
		if (srst) begin
			lineOn        <= '0;
			sinkOn        <= '0;
			lineDischarge <= 2'h0;
			sinkPrecharge <= 2'h0;
		end else begin
			lineOn <= '0;
			if (state_r == SC_LINE) begin
				lineOn[line_r] <= 1'b1;
			end
			// a delayed group is cut at line end so blank stays dark
			for (int s = 0; s < NUM_SINKS; s++) begin
				sinkOn[s] <= state_r == SC_LINE
					&& cnt_r >= grp_start(s % 3)
					&& cnt_r < grp_start(s % 3) + tPwm
					&& cnt_r < lineLen;
			end
			lineDischarge <= state_r == SC_BLANK ? upAct_r : 2'h0;
			sinkPrecharge <= state_r == SC_BLANK ? downAct_r : 2'h0;
		end
	end

	// per-sink gains for the line being scanned
	always_ff @(posedge clk) begin
		if (srst) begin
			sinkCtl <= '0;
		end else begin
			for (int s = 0; s < NUM_SINKS; s++) begin
				sinkCtl[s].lowLevelComp <= comp_r[s % 3];
				sinkCtl[s].colorGain <= colorAct_r[s % 3];
				sinkCtl[s].dotGain <= dotAct_r[8'(line_r * NUM_SINKS + s)];
				sinkCtl[s].currentUa <= sink_ua(peakAct_r,
					colorAct_r[s % 3],
					dotAct_r[8'(line_r * NUM_SINKS + s)]);
			end
		end
	end

	assign peakCurrentCode = peakAct_r;
endmodule
`default_nettype wire

// ==== lms_scan_gain_asserts.sv ====
// assertion checker for the led scan and gain block
`timescale 1ns/1ps
`default_nettype none
module lms_chk
	import lms_pkg::*;
#(
	parameter int NUM_LINES = 8,
	parameter int NUM_SINKS = 18
) (
	input wire logic                 clk,             // clock
	input wire logic                 srst,            // sync reset
	input wire logic [NUM_LINES-1:0] lineOn,          // scan lines
	input wire logic [NUM_SINKS-1:0] sinkOn,          // sinks
	input wire logic [1:0]           lineDischarge,   // up de-ghost
	input wire logic [1:0]           sinkPrecharge,   // down de-ghost
	input wire logic [2:0]           peakCurrentCode  // live peak
);
	logic [NUM_LINES-1:0] prevOn_r; // last lit line
	logic [7:0]           gap_r;    // dark cycles, saturating
	// last line and the dark run before the next one
	always_ff @(posedge clk) begin
		if (srst) begin
			prevOn_r <= '0;
			gap_r <= 8'h00;
		end else if (lineOn != '0) begin
			prevOn_r <= lineOn;
			gap_r <= 8'h00;
		end else if (gap_r != 8'hff) begin
			gap_r <= gap_r + 8'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// a line lights after at least one dark cycle
	sequence lineRise;
		(lineOn != '0) && (gap_r != 8'h00);
	endsequence
	// long gaps are idle time, not blanking
	sequence blankRise;
		lineRise ##0 ((prevOn_r != '0) && (gap_r < 8'd100));
	endsequence
	AST_ONE_LINE: assert property ($onehot0(lineOn))
		else $error("several scan lines on");
	AST_LINE_ORDER: assert property (lineRise |->
		(lineOn == (prevOn_r << 1)) || (lineOn == NUM_LINES'(1)))
		else $error("scan line out of order");
	AST_BLANK_LEN: assert property (blankRise |->
		(gap_r == 8'd13) || (gap_r == 8'd25))
		else $error("blank length wrong");
	AST_SINK_DARK: assert property (lineOn == '0 |-> sinkOn == '0)
		else $error("sink on with no line");
	AST_UP_IN_LINE: assert property (
		lineOn != '0 |-> lineDischarge == 2'h0)
		else $error("discharge during line");
	AST_DOWN_IN_LINE: assert property (
		lineOn != '0 |-> sinkPrecharge == 2'h0)
		else $error("precharge during line");
	AST_PEAK_LEGAL: assert property (peakCurrentCode != PEAK_BAD)
		else $error("illegal peak code");
	AST_SINK_START: assert property (lineRise |-> ##[0:2] sinkOn[0])
		else $error("sinks late after line start");
endmodule
bind lms_scan_gain lms_chk #(.NUM_LINES(NUM_LINES), .NUM_SINKS(NUM_SINKS))
	uChk (.clk(clk), .srst(srst), .lineOn(lineOn), .sinkOn(sinkOn),
	.lineDischarge(lineDischarge), .sinkPrecharge(sinkPrecharge),
	.peakCurrentCode(peakCurrentCode));
`default_nettype wire

// ==== lms_matrix_model.sv ====
// behavioural led matrix that records which lines glowed
`timescale 1ns/1ps
`default_nettype none
module lms_matrix_model (
	input  wire logic        clk,    // clock
	input  wire logic        clr,    // clear record
	input  wire logic [7:0]  lineOn, // scan switches
	input  wire logic [17:0] sinkOn, // sinks
	output logic      [7:0]  litRows // lines that glowed
);
	// a dot glows only while its line and a sink both conduct
	always_ff @(posedge clk) begin
		if (clr) litRows <= '0;
		else if (sinkOn != '0) litRows <= litRows | lineOn;
	end
endmodule
`default_nettype wire

// ==== lms_scan_gain_tb.sv ====
// self-checking bench for the led scan and gain block
`timescale 1ns/1ps
`default_nettype none
module lms_scan_gain_tb
	import lms_pkg::*;
;
	logic             clk;
	logic             srst;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [11:0]      paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [7:0]       lineOn;
	logic [17:0]      sinkOn;
	logic [1:0]       lineDischarge;
	logic [1:0]       sinkPrecharge;
	logic [2:0]       peakCurrentCode;
	lms_sink_s [17:0] sinkCtl;
	logic             clr;
	logic [7:0]       litRows;
	logic [31:0]      rq;
	logic             lastErr;
	logic [2:0]       pk;
	logic [2:0]       pk2;
	int               cv[3];
	int               cmp;
	int               num_errors;
	int               n_compared;

	lms_scan_gain DUT (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lineOn(lineOn), .sinkOn(sinkOn), .lineDischarge(lineDischarge),
		.sinkPrecharge(sinkPrecharge), .peakCurrentCode(peakCurrentCode),
		.sinkCtl(sinkCtl));
	lms_matrix_model uMat (.clk(clk), .clr(clr), .lineOn(lineOn),
		.sinkOn(sinkOn), .litRows(litRows));

	always #20 clk = ~clk;

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready, then an idle edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
		rq = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// edges until line k next switches on
	task automatic wt(input int k, output int c);
		c = 0;
		while (lineOn[k] === 1'b1 && c < 9000) begin
			@(posedge clk);
			c++;
		end
		while (lineOn[k] !== 1'b1 && c < 9000) begin
			@(posedge clk);
			c++;
		end
	endtask

	function automatic int linePer(bit sl, bit sb, bit ph);
		return int'(sl ? CYC_PWM_S : CYC_PWM_F) + (ph ? 2 * CYC_PHASE : 0)
			+ int'(sb ? CYC_BLK_S : CYC_BLK_L);
	endfunction

	function automatic longint expUa(int code, int cc, int dc);
		int hm[7] = '{15, 25, 50, 75, 100, 150, 200};
		return longint'(hm[code]) * 500 * cc * dc / 32385;
	endfunction

	// one scan count with random timing options
	task automatic scanRun(input int code);
		int per;
		int sub;
		int nl;
		bit sl;
		bit sb;
		bit ph;
		logic [1:0] up;
		logic [1:0] dn;
		sl = 1'($urandom);
		sb = 1'($urandom);
		ph = 1'($urandom);
		up = 2'($urandom);
		dn = 2'($urandom);
		// the spare code runs the full eight lines
		nl = (code == 3) ? 8 : SCAN_MIN + code;
		apb(1'b1, OFS_CHIP, 32'h0);
		apb(1'b1, OFS_INIT, 32'(code) | (32'(sl) << 2) | 32'h10);
		apb(1'b1, OFS_CFG1, 32'(sb) | (32'(ph) << 1) | 32'($urandom % 2) << 2);
		apb(1'b1, OFS_CFG3, 32'(up) | (32'(dn) << 2));
		// idle long enough that the checker sees no blank
		repeat (120) @(posedge clk);
		apb(1'b1, OFS_CHIP, 32'h1);
		wt(0, per);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wt(1, per);
		wt(0, sub);
		chk(per + 1, linePer(sl, sb, ph));
		chk(per + 1 + sub, nl * linePer(sl, sb, ph));
		chk(litRows, (32'h1 << nl) - 1);
		while (lineOn[0] === 1'b1) @(posedge clk);
		chk(lineDischarge, up);
		chk(sinkPrecharge, dn);
		$display("test scan %0d lines done", nl);
	endtask

	initial begin
		#(40 * 60000);
		num_errors++;
		close_out;
	end

	initial begin
		clk = 1'b0;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		clr = 1'b0;
		void'($urandom(25));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		apb(1'b0, OFS_PEAK, 32'h0);
		chk(rq, 32'h3);
		chk(peakCurrentCode, 32'h3);
		for (int g = 0; g < 3; g++) begin
			apb(1'b0, OFS_COLOR + 12'(4 * g), 32'h0);
			chk(rq, 32'h40);
		end
		apb(1'b0, OFS_DOT, 32'h0);
		chk(rq, 32'h80);
		apb(1'b0, 12'h030, 32'h0);
		chk(lastErr, 32'h1);
		$display("test reset values done");
		for (int s = 0; s < 4; s++) scanRun(s);
		// skip the reset code so the immediate update is visible
		pk = 3'($urandom % 6);
		if (pk >= RST_PEAK) pk = pk + 3'h1;
		apb(1'b1, OFS_PEAK, 32'(pk));
		repeat (2) @(posedge clk);
		chk(peakCurrentCode, 32'(pk));
		// the unused code must be dropped
		apb(1'b1, OFS_PEAK, 32'(PEAK_BAD));
		chk(peakCurrentCode, 32'(pk));
		// frame modes: peak held until chip enable returns
		for (int m = 2; m < 4; m++) begin
			pk2 = (pk == 3'h6) ? 3'h0 : pk + 3'h1;
			apb(1'b1, OFS_INIT, 32'h2 | 32'(m << 4));
			apb(1'b1, OFS_CHIP, 32'h1);
			apb(1'b1, OFS_PEAK, 32'(pk2));
			chk(peakCurrentCode, 32'(pk));
			apb(1'b1, OFS_CHIP, 32'h0);
			apb(1'b1, OFS_PEAK, 32'(pk2));
			apb(1'b1, OFS_CFG3, 32'(m));
			chk(peakCurrentCode, 32'(pk));
			repeat (120) @(posedge clk);
			apb(1'b1, OFS_CHIP, 32'h1);
			repeat (2) @(posedge clk);
			chk(peakCurrentCode, 32'(pk2));
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(rq & 32'hf000, 32'(m) << 12);
			// frame sync: a color write stays pending until the sync
			apb(1'b1, OFS_COLOR, 32'(m));
			repeat (2) @(posedge clk);
			cmp = (m == 2) ? int'(RST_COLOR) : m - 1;
			chk(sinkCtl[0].colorGain, 32'(cmp));
			apb(1'b1, OFS_FSYNC, 32'h1);
			repeat (2) @(posedge clk);
			chk(sinkCtl[0].colorGain, 32'(m));
			pk = pk2;
		end
		$display("test peak latching done");
		apb(1'b1, OFS_INIT, 32'h12);
		for (int g = 0; g < 3; g++) begin
			cv[g] = $urandom % 128;
			apb(1'b1, OFS_COLOR + 12'(4 * g), 32'(cv[g]));
		end
		cmp = $urandom % 64;
		apb(1'b1, OFS_CFG2, 32'(cmp));
		// full-scale dot gain on sink zero of every line
		for (int l = 0; l < 8; l++) apb(1'b1, OFS_DOT + 12'(72 * l), 32'hff);
		repeat (3) @(posedge clk);
		for (int g = 0; g < 3; g++) begin
			chk(sinkCtl[g].colorGain, 32'(cv[g]));
			chk(sinkCtl[g].lowLevelComp, (cmp >> (2 * g)) & 3);
		end
		chk(sinkCtl[0].dotGain, 32'hff);
		chk(sinkCtl[0].currentUa, 32'(expUa(pk, cv[0], 255)));
		$display("test current gain done");
		close_out;
	end
endmodule
`default_nettype wire
